//--- logic/lcd_drive_pkg.sv
package lcd_drive_pkg;

  // Backplane half period in oscillator cycles
  localparam int unsigned BP_HALF_CYCLES    = 4096;
  // Seven segments per full digit, two for the half digit
  localparam int unsigned SEG_PER_DIGIT     = 7;
  localparam int unsigned FULL_DIGITS       = 3;
  localparam int unsigned HALF_SEGS         = 2;
  localparam int unsigned SEG_COUNT         = FULL_DIGITS * SEG_PER_DIGIT + HALF_SEGS;
  // Segment patterns (bit0 = a .. bit6 = g), 1 = lit
  localparam logic [6:0]  SEG_BLANK         = 7'h00;
  localparam logic [3:0]  BCD_WIDTH_MAX     = 4'h9;
  // Reset values
  localparam logic        BP_RESET          = 1'b0;
  localparam logic [11:0] COUNT_RESET       = 12'h000;

  // Measurement sequencer states
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HOLD = 3'b010,
    ST_START = 3'b100
  } seq_state_type;

endpackage : lcd_drive_pkg

//--- logic/lcd_drive_and_display_hold.sv
// Functional notes
// - Hold grounded keeps last valid result displayed
// - Hold request clears measurement counters
// - Hold release starts new measurement immediately
// - Backplane square wave, lit segments antiphase
// - Grounded backplane stops segment alternation
// - Static mode: active segment low, inactive high
// - Drive all three-and-a-half digit segments
// - Overrange shows leading one, others blanked
`timescale 1ns/10ps
`default_nettype none

module lcd_drive_and_display_hold
  import lcd_drive_pkg::*;
#(
  parameter int unsigned BP_HALF = BP_HALF_CYCLES
)
(
  input  wire logic                 mclk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 hold_n_i,
  input  wire logic                 bp_pin_i,
  input  wire logic                 result_valid_i,
  input  wire logic [3:0]           digit0_bcd_i,
  input  wire logic [3:0]           digit1_bcd_i,
  input  wire logic [3:0]           digit2_bcd_i,
  input  wire logic                 lead_one_i,
  input  wire logic                 overrange_i,
  output logic                      counters_clear_o,
  output logic                      meas_start_o,
  output logic                      bp_o,
  output logic                      bp_oe_n_o,
  output logic [SEG_COUNT-1:0]      seg_o
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic hold_meta_r;
  logic hold_sync_r;
  logic bp_meta_r;
  logic bp_sync_r;
  logic hold_act;

  // Two stage synchronisers for pins
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      hold_meta_r <= 1'b1;
      hold_sync_r <= 1'b1;
      bp_meta_r   <= 1'b0;
      bp_sync_r   <= 1'b0;
    end
    else
    begin
      hold_meta_r <= hold_n_i;
      hold_sync_r <= hold_meta_r;
      bp_meta_r   <= bp_pin_i;
      bp_sync_r   <= bp_meta_r;
    end
  end

  assign hold_act = ~hold_sync_r;

  // ************************************************************
  // Hold sequencer
  // ************************************************************
  seq_state_type state_r;
  seq_state_type state_nxt;

  // Next state for hold handling
  always_comb
  begin
    case (state_r)
      ST_RUN:   state_nxt = hold_act ? ST_HOLD : ST_RUN;
      ST_HOLD:  state_nxt = hold_act ? ST_HOLD : ST_START;
      ST_START: state_nxt = hold_act ? ST_HOLD : ST_RUN;
      default:  state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      state_r <= ST_START;
    else
      state_r <= state_nxt;
  end

  // Clear counters throughout hold, restart on release
  assign counters_clear_o = (state_r == ST_HOLD);
  assign meas_start_o     = (state_r == ST_START);

  // ************************************************************
  // Display latch
  // ************************************************************
  logic [3:0] d0_r;
  logic [3:0] d1_r;
  logic [3:0] d2_r;
  logic       lead_r;
  logic       over_r;

  // Capture only valid results outside hold
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      d0_r   <= 4'h0;
      d1_r   <= 4'h0;
      d2_r   <= 4'h0;
      lead_r <= 1'b0;
      over_r <= 1'b0;
    end
    else if (result_valid_i && !hold_act && state_r != ST_HOLD)
    begin
      d0_r   <= digit0_bcd_i;
      d1_r   <= digit1_bcd_i;
      d2_r   <= digit2_bcd_i;
      lead_r <= lead_one_i;
      over_r <= overrange_i;
    end
  end

  // ************************************************************
  // Segment decode
  // ************************************************************
  function automatic logic [6:0] bcd_to_seg(input logic [3:0] bcd);
    case (bcd)
      4'h0:    bcd_to_seg = 7'h3f;
      4'h1:    bcd_to_seg = 7'h06;
      4'h2:    bcd_to_seg = 7'h5b;
      4'h3:    bcd_to_seg = 7'h4f;
      4'h4:    bcd_to_seg = 7'h66;
      4'h5:    bcd_to_seg = 7'h6d;
      4'h6:    bcd_to_seg = 7'h7d;
      4'h7:    bcd_to_seg = 7'h07;
      4'h8:    bcd_to_seg = 7'h7f;
      4'h9:    bcd_to_seg = 7'h6f;
      default: bcd_to_seg = SEG_BLANK;
    endcase
  endfunction

  logic [SEG_COUNT-1:0] lit;

  // Overrange blanks full digits and forces leading one
  always_comb
  begin
    if (over_r)
      lit = {2'b11, SEG_BLANK, SEG_BLANK, SEG_BLANK};
    else
      lit = {{2{lead_r}}, bcd_to_seg(d2_r), bcd_to_seg(d1_r), bcd_to_seg(d0_r)};
  end

  // ************************************************************
  // Backplane divider
  // ************************************************************
  logic [15:0] div_r;
  logic        bp_r;

  // Divide clock down to backplane square wave
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      div_r <= 16'h0000;
      bp_r  <= BP_RESET;
    end
    else if (div_r == 16'(BP_HALF - 1))
    begin
      div_r <= 16'h0000;
      bp_r  <= ~bp_r;
    end
    else
      div_r <= div_r + 16'h0001;
  end

  // Backplane pin: drive while enable low; pin reads low when held externally
  assign bp_o      = bp_r;
  assign bp_oe_n_o = 1'b0;

  // ************************************************************
  // Grounded backplane detection
  // ************************************************************
  logic bp_d1_r;
  logic bp_d2_r;
  logic static_r;

  // Delay the drive by the synchroniser depth so drive and sensed pin line up
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      bp_d1_r <= 1'b0;
      bp_d2_r <= 1'b0;
    end
    else
    begin
      bp_d1_r <= bp_r;
      bp_d2_r <= bp_d1_r;
    end
  end

  // Pin low while driven high means grounded; kept through the low phase
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      static_r <= 1'b0;
    else if (bp_d2_r)
      static_r <= ~bp_sync_r;
  end

  // ************************************************************
  // Segment outputs
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < SEG_COUNT; gi++)
    begin : g_seg
      always_ff @(posedge mclk_i)
      begin
        if (!reset_n_i)
          seg_o[gi] <= 1'b1;
        else if (static_r)
          seg_o[gi] <= ~lit[gi];
        else
          seg_o[gi] <= lit[gi] ? ~bp_r : bp_r;
      end
    end
  endgenerate

endmodule // lcd_drive_and_display_hold

`default_nettype wire

//--- test/lcd_drive_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// Checker
// ***
module lcd_drive_asserts
  import lcd_drive_pkg::*;
#(
  parameter int unsigned BP_HALF = 4
)
(
  input wire logic                 mclk_i,
  input wire logic                 reset_n_i,
  input wire logic                 hold_n_i,
  input wire logic                 bp_pin_i,
  input wire logic                 counters_clear_o,
  input wire logic                 meas_start_o,
  input wire logic                 bp_o,
  input wire logic [SEG_COUNT-1:0] seg_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Hold entry and release answers
  sequence s_clr; ##2 !counters_clear_o ##1 counters_clear_o; endsequence
  sequence s_go; ##2 !meas_start_o ##1 meas_start_o && !counters_clear_o; endsequence
  a_hold_clears: assert property ($fell(hold_n_i) |-> s_clr) else $error("late clear");
  a_clear_stays: assert property (counters_clear_o && !hold_n_i |=> counters_clear_o) else $error("clear lost");
  a_release_starts: assert property ($rose(hold_n_i) |-> s_go) else $error("late start");
  a_start_once: assert property (meas_start_o |=> !meas_start_o) else $error("long start");
  a_no_start_hold: assert property (counters_clear_o |-> !meas_start_o) else $error("start in hold");
  a_clear_tracks: assert property (counters_clear_o == !$past(hold_n_i, 3)) else $error("clear off hold");
  a_bp_period: assert property ($changed(bp_o) |-> $past(bp_o) == $past(bp_o, BP_HALF)) else $error("bad half");
  a_seg_flip: assert property ($changed(bp_o) && bp_pin_i == bp_o && counters_clear_o && $past(counters_clear_o, 2)
    |=> seg_o == ~$past(seg_o)) else $error("no antiphase");
  a_seg_frozen: assert property (counters_clear_o && $past(counters_clear_o, 2) && $stable(bp_o) ##1 $stable(bp_o)
    |-> $stable(seg_o)) else $error("hold moved");
endmodule // lcd_drive_asserts
bind lcd_drive_and_display_hold lcd_drive_asserts #(.BP_HALF(BP_HALF)) lcd_drive_asserts_i (.mclk_i, .reset_n_i,
  .hold_n_i, .bp_pin_i, .counters_clear_o, .meas_start_o, .bp_o, .seg_o);
`default_nettype wire

//--- test/lcd_panel_model.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// Panel with select gate
// ***
module lcd_panel_model
(
  input  wire logic bp_i,
  input  wire logic bp_oe_n_i,
  input  wire logic ground_i,
  input  wire logic dp_sel_i,
  output logic      bp_pin_o,
  output logic      dp_drv_o
);
  // Grounding wins over the drive
  assign bp_pin_o = (ground_i || bp_oe_n_i) ? 1'h0 : bp_i;
  // Selected point in antiphase
  assign dp_drv_o = bp_i ^ dp_sel_i;
endmodule // lcd_panel_model
`default_nettype wire

//--- test/test_lcd_drive_and_display_hold.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// Testbench
// ***
module test_lcd_drive_and_display_hold;
  import lcd_drive_pkg::*;
  logic mclk_i = 1'h0, reset_n_i = 1'h0, hold_n_i = 1'h1, result_valid_i = 1'h0, lead_one_i, overrange_i;
  logic [3:0] digit0_bcd_i = 4'h0, digit1_bcd_i = 4'h0, digit2_bcd_i = 4'h0;
  logic bp_pin_i, counters_clear_o, meas_start_o, bp_o, bp_oe_n_o, gnd = 1'h0, dp, sel = 1'h1;
  logic [SEG_COUNT-1:0] seg_o;
  logic [SEG_COUNT-1:0] lit = {2'h3, 7'h3f, 7'h06, 7'h7f};
  int miscompares = 0, n_compared = 0;
  always #2.5 mclk_i = ~mclk_i;
  lcd_drive_and_display_hold #(.BP_HALF(6)) lcd_drive_and_display_hold_i (.mclk_i, .reset_n_i, .hold_n_i,
    .bp_pin_i, .result_valid_i, .digit0_bcd_i, .digit1_bcd_i, .digit2_bcd_i, .lead_one_i, .overrange_i,
    .counters_clear_o, .meas_start_o, .bp_o, .bp_oe_n_o, .seg_o);
  lcd_panel_model lcd_panel_model_i (.bp_i(bp_o), .bp_oe_n_i(bp_oe_n_o), .ground_i(gnd), .dp_sel_i(sel),
    .bp_pin_o(bp_pin_i), .dp_drv_o(dp));
  task wrap_up;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [SEG_COUNT-1:0] s, input logic [SEG_COUNT-1:0] e);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Waits until the backplane has sat at v for four cycles
  task ph(input logic v);
    int c;
    c = 0;
    for (int k = 0; k < 40 && c < 4; k++)
    begin
      @(negedge mclk_i);
      c = (bp_o === v) ? c + 1 : 0;
    end
    if (c < 4)
    begin
      miscompares++;
      wrap_up();
    end
  endtask
  task ld(input logic [3:0] a, input logic o);
    @(negedge mclk_i);
    {digit0_bcd_i, digit1_bcd_i, lead_one_i, overrange_i, result_valid_i} = {a, 4'h1, 1'h1, o, 1'h1};
    @(negedge mclk_i);
    result_valid_i = 1'h0;
  endtask
  task t_over;
    ld(4'h8, 1'h1);
    ph(1'h0);
    chk(seg_o, {2'h3, 21'h0});
    $display("t_over end");
  endtask
  task t_normal;
    ld(4'h8, 1'h0);
    ph(1'h1);
    chk(seg_o, ~lit);
    chk({22'h0, dp}, 23'h0);
    ph(1'h0);
    chk(seg_o, lit);
    chk({22'h0, dp}, 23'h1);
    sel = 1'h0;
    @(negedge mclk_i);
    chk({22'h0, dp}, 23'h0);
    sel = 1'h1;
    $display("t_normal end");
  endtask
  task t_hold;
    hold_n_i = 1'h0;
    repeat (6) @(negedge mclk_i);
    chk({22'h0, counters_clear_o}, 23'h1);
    ld(4'h1, 1'h1);
    ph(1'h0);
    chk(seg_o, lit);
    hold_n_i = 1'h1;
    for (int k = 0; k < 8 && meas_start_o !== 1'h1; k++) @(negedge mclk_i);
    chk({22'h0, meas_start_o}, 23'h1);
    $display("t_hold end");
  endtask
  task t_static;
    gnd = 1'h1;
    ph(1'h1);
    ph(1'h0);
    chk(seg_o, ~lit);
    gnd = 1'h0;
    ph(1'h1);
    ph(1'h0);
    chk(seg_o, lit);
    $display("t_static end");
  endtask
  initial
  begin
    repeat (10) @(negedge mclk_i);
    reset_n_i = 1'h1;
    t_over();
    t_normal();
    t_hold();
    t_static();
    wrap_up();
  end
endmodule // test_lcd_drive_and_display_hold
`default_nettype wire
